// *** verilog/dswake_top.sv ***
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "dswake_regs.svh"

// Register map, byte offsets
//   0x00  wake cause flags, a read returns them and clears them
//   0x04  wake source enables
//   0x08  wake pin polarity, bits 4:0 for pins 5:1, one = high level
//   0x0c  interrupt status, read only
//   0x10  interrupt clear, write ones to clear
//   0x14  interrupt enable
//   other offsets read zero and ignore writes
//
// Flag and enable layout
//   bit 0       RTC interrupt
//   bit 1       low-voltage interrupt
//   bits 7:2    wake pins 5:0 (enable bit 2 reserved, pin 0 always on)
//   bits 9:8    remote receive channels 1:0
//   bits 15:10  reserved, read zero
//
// Interrupt status layout
//   bit 0       a wake hit ended standby
//   bit 1       flags were read while any was set
//
// Wake walk
//   standby_enter in run moves to standby at the next edge
//   an enabled, active source in standby sets its flag at the next edge,
//   pulses wake_req and drops in_standby; run follows one cycle later
//   flags are never set outside standby, so software must read them
//   clear before it enters standby again
//   the standby transition reset input is kept for the pin-out only:
//   nothing in this block is cleared by it

module dswake_top
   import dswake_pkg::*;
#(
   parameter int NPINS = 6
)
(
   // Clock, reset, enable
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   // Extra reset sources
   input  wire logic              lvd_reset,
   input  wire logic [3:0]        voltage_level_select,
   input  wire logic              lvl_gated_variant,
   input  wire logic              standby_reset,
   // Power mode control
   input  wire logic              standby_enter,
   // Wake sources
   input  wire logic [NPINS-1:0]  wake_pin_n,
   input  wire logic              lvd_irq,
   input  wire logic              rtc_irq,
   input  wire logic              cec_ch0_irq,
   input  wire logic              cec_ch1_irq,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [15:0]       reg_rdata,
   // Status
   output logic                   in_standby,
   output logic                   wake_req,
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////
   dswake_state_e state_q;
   dswake_word_t  flags_q;
   dswake_word_t  enables_q;
   logic [4:0]    polarity_q;
   logic [1:0]    irq_stat_q;
   logic [1:0]    irq_en_q;
   dswake_word_t  src_active;
   dswake_word_t  src_allowed;
   dswake_word_t  hits;
   logic          flags_clear;
   logic          flags_rd;
   dswake_state_e state_d;
   dswake_word_t  flags_d;
   dswake_word_t  rdata_d;
   logic [1:0]    irq_stat_d;
   logic [1:0]    irq_events;
   logic          wr_enables;
   logic          wr_polarity;
   logic          wr_irq_clr;
   logic          wr_irq_en;

   assign flags_rd    = reg_rd && (reg_addr == `DSWAKE_FLAGS_OFS);
   assign flags_clear = lvd_reset &&
                        (!lvl_gated_variant || voltage_level_select == `DSWAKE_LVL_CLEAR);

   // Write strobes, one per writable register
   assign wr_enables  = reg_wr && (reg_addr == `DSWAKE_ENABLES_OFS);
   assign wr_polarity = reg_wr && (reg_addr == `DSWAKE_POLARITY_OFS);
   assign wr_irq_clr  = reg_wr && (reg_addr == `DSWAKE_IRQ_CLR_OFS);
   assign wr_irq_en   = reg_wr && (reg_addr == `DSWAKE_IRQ_EN_OFS);

   ////////////////////////////////////////////////////////////////////////////
   // Source request levels
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++)
      begin : g_pin
         if (gi == 0)
         begin : g_zero
            assign src_active[`DSWAKE_PIN_LSB]  = !wake_pin_n[0];
            assign src_allowed[`DSWAKE_PIN_LSB] = 1'b1;
         end
         else
         begin : g_n
            assign src_active[`DSWAKE_PIN_LSB+gi]  = wake_pin_n[gi] == polarity_q[gi-1];
            assign src_allowed[`DSWAKE_PIN_LSB+gi] = enables_q[`DSWAKE_PIN_LSB+gi];
         end
      end
   endgenerate

   assign src_active[`DSWAKE_RTC_BIT]   = rtc_irq;
   assign src_active[`DSWAKE_LVD_BIT]   = lvd_irq;
   assign src_active[`DSWAKE_CEC0_BIT]  = cec_ch0_irq;
   assign src_active[`DSWAKE_CEC1_BIT]  = cec_ch1_irq;
   assign src_active[15:10]             = 6'h00;
   assign src_allowed[`DSWAKE_RTC_BIT]  = enables_q[`DSWAKE_RTC_BIT];
   assign src_allowed[`DSWAKE_LVD_BIT]  = enables_q[`DSWAKE_LVD_BIT];
   assign src_allowed[`DSWAKE_CEC0_BIT] = enables_q[`DSWAKE_CEC0_BIT];
   assign src_allowed[`DSWAKE_CEC1_BIT] = enables_q[`DSWAKE_CEC1_BIT];
   assign src_allowed[15:10]            = 6'h00;

   // Only enabled sources and pin 0 (always on) count, and only in standby
   assign hits = (state_q == DSWAKE_STANDBY) ?
                 (src_active & src_allowed & `DSWAKE_FLAG_MASK) : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Power mode sequence
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         DSWAKE_RUN:
         begin
            if (standby_enter)
               state_d = DSWAKE_STANDBY;
         end
         DSWAKE_STANDBY:
         begin
            if (|hits)
               state_d = DSWAKE_WAKING;
         end
         DSWAKE_WAKING:
         begin
            state_d = DSWAKE_RUN;
         end
         default:
         begin
            // Code 2'b11 is unused; recover to run
            state_d = DSWAKE_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= DSWAKE_RUN;
      else if (clk_en)
         state_q <= state_d;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_standby <= 1'b0;
         wake_req   <= 1'b0;
      end
      else if (clk_en)
      begin
         in_standby <= (state_q == DSWAKE_STANDBY) && !(|hits);
         wake_req   <= |hits;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wake cause flags: untouched by the standby transition reset.
   // A hit in the read cycle is kept, so a read never loses a wake cause.
   genvar fi;
   generate
      for (fi = 0; fi < 16; fi++)
      begin : g_flag
         assign flags_d[fi] = flags_clear ? 1'b0 :
                              flags_rd    ? hits[fi] :
                                            (flags_q[fi] | hits[fi]);
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         flags_q <= `DSWAKE_FLAGS_RST;
      else if (clk_en)
         flags_q <= flags_d;
   end

   // Enables and polarity also survive the standby transition reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enables_q  <= `DSWAKE_ENABLES_RST;
         polarity_q <= `DSWAKE_POLARITY_RST;
      end
      else if (clk_en)
      begin
         if (wr_enables)
            enables_q <= reg_wdata & `DSWAKE_EN_MASK;
         if (wr_polarity)
            polarity_q <= reg_wdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: bit0 wake event, bit1 flag read while set
   assign irq_events = {flags_rd && (|flags_q), |hits};

   // An event in the clear cycle wins over the clear
   genvar ii;
   generate
      for (ii = 0; ii < 2; ii++)
      begin : g_irq
         assign irq_stat_d[ii] = irq_events[ii] | (irq_stat_q[ii] & ~(wr_irq_clr & reg_wdata[ii]));
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_q <= `DSWAKE_IRQ_RST;
      else if (clk_en)
         irq_stat_q <= irq_stat_d;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq_en_q <= `DSWAKE_IRQ_RST;
      else if (clk_en && wr_irq_en)
         irq_en_q <= reg_wdata[1:0];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else if (clk_en)
         irq <= |(irq_stat_q & irq_en_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data select; zero whenever no read is strobed
   always_comb
   begin
      rdata_d = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `DSWAKE_FLAGS_OFS:    rdata_d = flags_q & `DSWAKE_FLAG_MASK;
            `DSWAKE_ENABLES_OFS:  rdata_d = enables_q & `DSWAKE_EN_MASK;
            `DSWAKE_POLARITY_OFS: rdata_d = {11'h000, polarity_q};
            `DSWAKE_IRQ_STAT_OFS: rdata_d = {14'h0000, irq_stat_q};
            `DSWAKE_IRQ_EN_OFS:   rdata_d = {14'h0000, irq_en_q};
            default:              rdata_d = 16'h0000;
         endcase
      end
   end

   // Read data, valid the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (clk_en)
         reg_rdata <= rdata_d;
   end

endmodule : dswake_top

// *** verilog/dswake_regs.svh ***
`ifndef DSWAKE_REGS_SVH
`define DSWAKE_REGS_SVH
// Register byte offsets
`define DSWAKE_FLAGS_OFS     8'h00
`define DSWAKE_ENABLES_OFS   8'h04
`define DSWAKE_POLARITY_OFS  8'h08
`define DSWAKE_IRQ_STAT_OFS  8'h0c
`define DSWAKE_IRQ_CLR_OFS   8'h10
`define DSWAKE_IRQ_EN_OFS    8'h14
// Field positions
`define DSWAKE_RTC_BIT       0
`define DSWAKE_LVD_BIT       1
`define DSWAKE_PIN_LSB       2
`define DSWAKE_PIN_MSB       7
`define DSWAKE_CEC0_BIT      8
`define DSWAKE_CEC1_BIT      9
// Writable enable bits: 9:8, 7:3, 1:0
`define DSWAKE_EN_MASK       16'h03fb
`define DSWAKE_FLAG_MASK     16'h03ff
// Reset values
`define DSWAKE_FLAGS_RST     16'h0000
`define DSWAKE_ENABLES_RST   16'h0000
`define DSWAKE_POLARITY_RST  5'h00
`define DSWAKE_IRQ_RST       2'h0
// Voltage level code at which a low-voltage reset clears the flags
`define DSWAKE_LVL_CLEAR     4'h1
`endif

// *** verilog/dswake_pkg.sv ***
package dswake_pkg;
   typedef logic [15:0] dswake_word_t;
   typedef enum logic [1:0]
   {
      DSWAKE_RUN     = 2'b00,
      DSWAKE_STANDBY = 2'b01,
      DSWAKE_WAKING  = 2'b10
   } dswake_state_e;
endpackage : dswake_pkg

// *** verification/dswake_sva.sv ***
`timescale 1ns/1ps
module dswake_sva
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        standby_enter,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        in_standby,
   input wire logic        wake_req
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_rsvd; reg_rdata[15:10] == 6'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
   property p_enrd; clk_en && reg_rd && reg_addr == 8'h04 |=> (reg_rdata & 16'hfc04) == 16'h0000; endproperty
   a_enrd: assert property (p_enrd) else $error("reserved enable bit set");
   property p_unmap; clk_en && reg_rd && reg_addr > 8'h14 |=> reg_rdata == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
   property p_idle; clk_en && !reg_rd |=> reg_rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data without read");
   property p_rdclr;
      (clk_en && reg_rd && reg_addr == 8'h00 && !in_standby && !standby_enter && !$past(standby_enter)) ##2
      (clk_en && reg_rd && reg_addr == 8'h00) |=> reg_rdata == 16'h0000;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("flags not cleared by read");
   property p_leave; in_standby ##1 !in_standby |-> wake_req; endproperty
   a_leave: assert property (p_leave) else $error("standby left without wake");
   property p_pulse; wake_req && clk_en |=> !wake_req; endproperty
   a_pulse: assert property (p_pulse) else $error("wake request too long");
   property p_wout; wake_req |-> !in_standby; endproperty
   a_wout: assert property (p_wout) else $error("wake request while in standby");
endmodule : dswake_sva
bind dswake_top dswake_sva u_dswake_sva (.clk_sys, .rst_n, .clk_en, .standby_enter, .reg_addr, .reg_rd,
   .reg_rdata, .in_standby, .wake_req);

// *** verification/dswake_top_tb.sv ***
`timescale 1ns/1ps
module dswake_top_tb;
   import dswake_pkg::*;
   logic         clk_sys = 0, rst_n = 0, lvd_reset = 0, standby_reset = 0, standby_enter = 0;
   logic         reg_wr = 0, reg_rd = 0, lvd_irq, rtc_irq, cec_ch0_irq, cec_ch1_irq, in_standby, wake_req, irq;
   logic [9:0]   act = 10'h000;
   logic         clk_en = 1'b1, lvl_gated_variant = 1'b0;
   logic [3:0]   voltage_level_select = 4'h1;
   logic [5:0]   wake_pin_n;
   logic [7:0]   reg_addr = 8'h00;
   dswake_word_t reg_wdata = 16'h0000, reg_rdata;
   int           num_errors = 0, checked = 0;
   always #5 clk_sys = ~clk_sys;
   // Source vector laid out like the flag register
   assign {cec_ch1_irq, cec_ch0_irq, wake_pin_n, lvd_irq, rtc_irq} = {act[9:8], ~act[7:2], act[1:0]};
   dswake_top u_dswake_top (.clk_sys, .rst_n, .clk_en, .lvd_reset, .voltage_level_select,
      .lvl_gated_variant, .standby_reset, .standby_enter, .wake_pin_n, .lvd_irq, .rtc_irq, .cec_ch0_irq,
      .cec_ch1_irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_standby, .wake_req, .irq);
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      num_errors += (got !== exp);
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
      @(posedge clk_sys);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(nm, exp, reg_rdata);
   endtask : rd
   task automatic doze(input int b, input logic exp);
      @(posedge clk_sys);
      standby_enter <= 1'b1;
      @(posedge clk_sys);
      standby_enter <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("asleep", 1'b1, in_standby);
      @(posedge clk_sys);
      act[b] <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("woken", !exp, in_standby);
      @(posedge clk_sys);
      act[b] <= 1'b0;
   endtask : doze
   task automatic tally_and_finish();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(8'h00, 16'h0000, "flags");
      rd(8'h04, 16'h0000, "enables");
      wr(8'h04, 16'hffff);
      rd(8'h04, 16'h03fb, "enables");
      rd(8'h18, 16'h0000, "unmapped");
      wr(8'h14, 16'h0001);
      $display("registers done");
      for (int b = 0; b < 10; b++)
      begin
         doze(b, 1'b1);
         #1 chk("irq", 1'b1, irq);
         rd(8'h00, 16'h0001 << b, "flags");
         rd(8'h00, 16'h0000, "flags");
         rd(8'h0c, 16'h0003, "irq status");
         wr(8'h10, 16'h0003);
      end
      repeat (2) @(negedge clk_sys);
      chk("irq", 1'b0, irq);
      $display("wake sources done");
      wr(8'h04, 16'h0000);
      wr(8'h14, 16'h0000);
      for (int b = 0; b < 10; b++)
         if (b != 2) doze(b, 1'b0);
      @(posedge clk_sys);
      act[2] <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("pin0 wake", 1'b0, in_standby);
      chk("irq masked", 1'b0, irq);
      @(posedge clk_sys);
      act[2] <= 1'b0;
      rd(8'h00, 16'h0004, "flags");
      $display("disabled sources done");
      wr(8'h04, 16'h0001);
      @(posedge clk_sys);
      {act[0], standby_reset} <= 2'b11;
      @(posedge clk_sys);
      {act[0], standby_reset} <= 2'b00;
      rd(8'h00, 16'h0000, "flags");
      rd(8'h04, 16'h0001, "enables");
      doze(2, 1'b1);
      @(posedge clk_sys);
      lvd_reset <= 1'b1;
      @(posedge clk_sys);
      lvd_reset <= 1'b0;
      rd(8'h00, 16'h0000, "flags");
      $display("resets done");
      @(posedge clk_sys);
      {lvl_gated_variant, voltage_level_select} <= 5'h10;
      doze(2, 1'b1);
      @(posedge clk_sys);
      lvd_reset <= 1'b1;
      @(posedge clk_sys);
      {lvd_reset, clk_en} <= 2'b00;
      rd(8'h00, 16'h0000, "frozen read");
      @(posedge clk_sys);
      clk_en <= 1'b1;
      rd(8'h00, 16'h0004, "gated flags");
      $display("gating done");
      wr(8'h08, 16'h0001);
      wr(8'h04, 16'h0008);
      rd(8'h08, 16'h0001, "polarity");
      @(posedge clk_sys);
      {act[3], standby_enter} <= 2'b11;
      @(posedge clk_sys);
      standby_enter <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("low pin held", 1'b1, in_standby);
      @(posedge clk_sys);
      act[3] <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("high pin woke", 1'b0, in_standby);
      rd(8'h00, 16'h0008, "flags");
      $display("polarity done");
      tally_and_finish();
   end
endmodule : dswake_top_tb
